// >>> spc_params.svh
// Constants for the sensor pin control and pixel port
`ifndef SPC_PARAMS_SVH
`define SPC_PARAMS_SVH
`define SPC_ADDR_LOW 8'h78
`define SPC_ADDR_HIGH 8'h7a
`define SPC_RAW_MSB 9
`define SPC_RAW_LSB 2
`define SPC_PROC_MSB 7
`define SPC_TAG_DELAY 3'h5
`define SPC_TAG_RST 4'h0
`endif

// >>> spc_pkg.sv
// Types for the sensor pin control and pixel port
package spc_pkg;
  typedef enum logic [2:0] {
    FN_STROBE, FN_SHUTTER, FN_EXTRA0, FN_EXTRA1, FN_TAG, FN_OUT_EN,
    FN_TRIGGER
  } spc_gpio_fn_t;
  typedef spc_gpio_fn_t [3:0] spc_gpio_cfg_t;
  typedef enum logic [1:0] {TS_IDLE, TS_FRAME} spc_tstate_t;
  typedef struct packed {
    logic run;
    logic raw;
    logic serial;
    logic ce;
  } spc_ctrl_t;
  typedef struct packed {
    logic fv;
    logic lv;
    logic [7:0] data;
  } spc_pix_t;
endpackage

// >>> spc_frame_timer.sv
// Frame and line timing generator on the link clock
`timescale 1ns/10ps
module spc_frame_timer #(
  parameter int COLS = 16,
  parameter int ROWS = 8,
  parameter int HBLANK = 4,
  parameter int VBLANK = 6
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic step,
  input wire logic run,
  input wire logic trig_mode,
  input wire logic trig,
  output logic fv,
  output logic lv
);
  localparam int CW = $clog2(COLS + HBLANK);
  localparam int RW = $clog2(ROWS + VBLANK);
  localparam logic [CW-1:0] COL_LAST = CW'(COLS + HBLANK - 1);
  localparam logic [RW-1:0] ROW_LAST = RW'(ROWS + VBLANK - 1);
  localparam logic [CW-1:0] COL_ACT = CW'(COLS);
  localparam logic [RW-1:0] ROW_ACT = RW'(ROWS);

  spc_pkg::spc_tstate_t state_q;
  logic [CW-1:0] col_q;
  logic [RW-1:0] row_q;
  logic trig_seen_q;
  logic go;
  logic frame_end;
  logic start;

  assign go = run && (!trig_mode || trig_seen_q);
  assign frame_end = (col_q == COL_LAST) && (row_q == ROW_LAST);
  assign start = step && go &&
                 (state_q == spc_pkg::TS_IDLE || frame_end);

  // Frames chain back to back while run holds and, in trigger mode, a trigger is pending
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= spc_pkg::TS_IDLE;
      col_q <= '0;
      row_q <= '0;
    end else if (ce && step) begin
      case (state_q)
        spc_pkg::TS_IDLE: begin
          if (go) begin
            state_q <= spc_pkg::TS_FRAME;
          end
          col_q <= '0;
          row_q <= '0;
        end
        spc_pkg::TS_FRAME: begin
          if (col_q == COL_LAST) begin
            col_q <= '0;
            row_q <= (row_q == ROW_LAST) ? '0 : row_q + 1'b1;
            if (frame_end && !go) begin
              state_q <= spc_pkg::TS_IDLE;
            end
          end else begin
            col_q <= col_q + 1'b1;
          end
        end
        default: state_q <= spc_pkg::TS_IDLE;
      endcase
    end
  end

  // A trigger landing on the frame start is kept for the next frame
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trig_seen_q <= 1'b0;
    end else if (ce) begin
      trig_seen_q <= trig || (trig_seen_q && !start);
    end
  end

  assign fv = (state_q == spc_pkg::TS_FRAME) && (row_q < ROW_ACT);
  assign lv = fv && (col_q < COL_ACT);
endmodule // spc_frame_timer

// >>> spc_pin_port.sv
// Sensor pin control and parallel pixel port top level
`timescale 1ns/10ps
`include "spc_params.svh"
module spc_pin_port #(
  parameter int COLS = 16,
  parameter int ROWS = 8,
  parameter int HBLANK = 4,
  parameter int VBLANK = 6
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic REF_CLK_IN,
  input wire logic STANDBY_IN,
  input wire logic CORE_POWER_OFF_IN,
  input wire logic BUS_ADDR_SELECT,
  input wire logic PLL_BYPASS,
  input wire logic RAW_BYPASS,
  input wire logic SERIAL_SEL,
  input wire spc_pkg::spc_gpio_cfg_t GPIO_FUNC,
  input wire logic [3:0] GPIO_IN,
  input wire logic [9:0] IMG_WORD,
  input wire logic [7:0] LENS_DRIVE,
  input wire logic [7:0] LENS_DIR,
  output logic [7:0] BUS_ADDR,
  output logic STANDBY_ACT,
  output logic CORE_POWER_EN,
  output logic PLL_POWER_EN,
  output logic PLL_CLK_SEL,
  output logic SERIAL_LINK_EN,
  output logic PIXEL_SAMPLE_CLK,
  output logic [7:0] PIX_DATA,
  output logic LINE_VALID,
  output logic FRAME_VALID,
  output logic PAR_OUT_EN,
  output logic [3:0] GPIO_OUT,
  output logic [3:0] GPIO_OE,
  output logic [3:0] MODULE_TAG,
  output logic [7:0] LENS_ACTUATOR_PINS_O,
  output logic [7:0] LENS_ACTUATOR_PINS_OE
);
  // ---------------- System clock domain ----------------
  logic [2:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q;
  logic standby_f, off_f, addr_sel_f, par_s1_q, par_s2_q;
  spc_pkg::spc_ctrl_t ctrl_d;

  // Pins: change counts once stages two and three agree
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
      pin_s3_q <= 3'h0;
      pin_f_q <= 3'h0;
      par_s1_q <= 1'b0;
      par_s2_q <= 1'b0;
    end else if (CE) begin
      pin_s1_q <= {BUS_ADDR_SELECT, CORE_POWER_OFF_IN, STANDBY_IN};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      par_s1_q <= PAR_OUT_EN;
      par_s2_q <= par_s1_q;
      if (pin_s2_q == pin_s3_q) begin
        pin_f_q <= pin_s3_q;
      end
    end
  end
  assign {addr_sel_f, off_f, standby_f} = pin_f_q;

  // All control outputs held in their safe state during reset
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      BUS_ADDR <= `SPC_ADDR_LOW;
      STANDBY_ACT <= 1'b0;
      CORE_POWER_EN <= 1'b0;
      PLL_POWER_EN <= 1'b0;
      PLL_CLK_SEL <= 1'b0;
      SERIAL_LINK_EN <= 1'b0;
    end else if (CE) begin
      BUS_ADDR <= addr_sel_f ? `SPC_ADDR_HIGH : `SPC_ADDR_LOW;
      STANDBY_ACT <= standby_f;
      CORE_POWER_EN <= !off_f;
      PLL_POWER_EN <= !off_f && !PLL_BYPASS;
      PLL_CLK_SEL <= !PLL_BYPASS;
      // Serial waits until the parallel port is seen idle
      SERIAL_LINK_EN <= SERIAL_SEL && !off_f && !standby_f && !par_s2_q;
    end
  end

  // Lens pins float while the core is powered off
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      LENS_ACTUATOR_PINS_O <= 8'h00;
      LENS_ACTUATOR_PINS_OE <= 8'h00;
    end else if (CE) begin
      LENS_ACTUATOR_PINS_O <= LENS_DRIVE;
      LENS_ACTUATOR_PINS_OE <= off_f ? 8'h00 : LENS_DIR;
    end
  end

  assign ctrl_d.run = !standby_f && !off_f;
  assign ctrl_d.raw = RAW_BYPASS;
  assign ctrl_d.serial = SERIAL_SEL;
  assign ctrl_d.ce = CE;
  // ---------------- Link clock domain ----------------
  // Settings are quasi-static, so a plain two-flop crossing is enough;
  // CE therefore freezes the link side two link edges late.
  logic rst_m_q, rst_l_q;
  spc_pkg::spc_ctrl_t ctl_m_q, ctl_q;
  spc_pkg::spc_gpio_cfg_t fn_m_q, fn_q;
  logic ce_l;

  always_ff @(posedge REF_CLK_IN) begin
    rst_m_q <= RSTN;
    rst_l_q <= rst_m_q;
    ctl_m_q <= ctrl_d;
    ctl_q <= ctl_m_q;
    fn_m_q <= GPIO_FUNC;
    fn_q <= fn_m_q;
  end
  assign ce_l = ctl_q.ce;

  logic [3:0] g_s1_q, g_s2_q, g_s3_q, g_f_q, g_prev_q;
  always_ff @(posedge REF_CLK_IN) begin
    if (!rst_l_q) begin
      g_s1_q <= 4'h0;
      g_s2_q <= 4'h0;
      g_s3_q <= 4'h0;
      g_f_q <= 4'h0;
      g_prev_q <= 4'h0;
    end else if (ce_l) begin
      g_s1_q <= GPIO_IN;
      g_s2_q <= g_s1_q;
      g_s3_q <= g_s2_q;
      if (g_s2_q == g_s3_q) begin
        g_f_q <= g_s3_q;
      end
      g_prev_q <= g_f_q;
    end
  end

  function automatic logic [3:0] fn_mask(spc_pkg::spc_gpio_cfg_t cfg,
                                         spc_pkg::spc_gpio_fn_t fn);
    logic [3:0] m;
    m = 4'h0;
    for (int i = 0; i < 4; i++) begin
      m[i] = (cfg[i] == fn);
    end
    return m;
  endfunction

  logic [3:0] trig_m, oe_m, tag_m;
  logic trig_mode, trig, oe_ok, par_on;
  assign trig_m = fn_mask(fn_q, spc_pkg::FN_TRIGGER);
  assign oe_m = fn_mask(fn_q, spc_pkg::FN_OUT_EN);
  assign tag_m = fn_mask(fn_q, spc_pkg::FN_TAG);
  assign trig_mode = |trig_m;
  assign trig = |(trig_m & g_f_q & ~g_prev_q);
  // Output-enable pin is active low
  assign oe_ok = !(|(oe_m & g_f_q));
  assign par_on = ctl_q.run && !ctl_q.serial && oe_ok;

  // Pixel clock runs at half the link rate; outputs move on its fall
  logic step, fv_n, lv_n;
  assign step = ce_l && PIXEL_SAMPLE_CLK;

  always_ff @(posedge REF_CLK_IN) begin
    if (!rst_l_q) begin
      PIXEL_SAMPLE_CLK <= 1'b0;
    end else if (ce_l) begin
      PIXEL_SAMPLE_CLK <= par_on ? !PIXEL_SAMPLE_CLK : 1'b0;
    end
  end

  spc_frame_timer #(
    .COLS(COLS),
    .ROWS(ROWS),
    .HBLANK(HBLANK),
    .VBLANK(VBLANK)
  ) u_timer (
    .clk(REF_CLK_IN),
    .rst_n(rst_l_q),
    .ce(ce_l),
    .step(step),
    .run(ctl_q.run),
    .trig_mode(trig_mode),
    .trig(trig),
    .fv(fv_n),
    .lv(lv_n)
  );

  spc_pkg::spc_pix_t pix_d;
  always_comb begin
    pix_d.fv = fv_n;
    pix_d.lv = lv_n;
    pix_d.data = 8'h00;
    if (lv_n) begin
      pix_d.data = ctl_q.raw ? IMG_WORD[`SPC_RAW_MSB:`SPC_RAW_LSB]
                             : IMG_WORD[`SPC_PROC_MSB:0];
    end
  end

  // Data and qualifiers update at the pixel clock fall, and clear at once when the port turns off
  always_ff @(posedge REF_CLK_IN) begin
    if (!rst_l_q) begin
      PIX_DATA <= 8'h00;
      LINE_VALID <= 1'b0;
      FRAME_VALID <= 1'b0;
      PAR_OUT_EN <= 1'b0;
    end else if (ce_l) begin
      PAR_OUT_EN <= par_on;
      if (!par_on) begin
        PIX_DATA <= 8'h00;
        LINE_VALID <= 1'b0;
        FRAME_VALID <= 1'b0;
      end else if (step) begin
        PIX_DATA <= pix_d.data;
        LINE_VALID <= pix_d.lv;
        FRAME_VALID <= pix_d.fv;
      end
    end
  end

  // GPIO function outputs, aligned with the data word
  always_ff @(posedge REF_CLK_IN) begin
    if (!rst_l_q) begin
      GPIO_OUT <= 4'h0;
      GPIO_OE <= 4'h0;
    end else if (ce_l) begin
      for (int i = 0; i < 4; i++) begin
        case (fn_q[i])
          spc_pkg::FN_STROBE, spc_pkg::FN_SHUTTER,
          spc_pkg::FN_EXTRA0, spc_pkg::FN_EXTRA1: GPIO_OE[i] <= 1'b1;
          default: GPIO_OE[i] <= 1'b0;
        endcase
        if (step) begin
          case (fn_q[i])
            spc_pkg::FN_STROBE: GPIO_OUT[i] <= fv_n;
            spc_pkg::FN_SHUTTER: GPIO_OUT[i] <= ctl_q.run && !fv_n;
            spc_pkg::FN_EXTRA0: GPIO_OUT[i] <= lv_n && ctl_q.raw &&
                                               IMG_WORD[0];
            spc_pkg::FN_EXTRA1: GPIO_OUT[i] <= lv_n && ctl_q.raw &&
                                               IMG_WORD[1];
            default: GPIO_OUT[i] <= 1'b0;
          endcase
        end
      end
    end
  end

  // Tag is read once, after the pin filter has settled
  logic [2:0] tag_cnt_q;
  always_ff @(posedge REF_CLK_IN) begin
    if (!rst_l_q) begin
      tag_cnt_q <= 3'h0;
      MODULE_TAG <= `SPC_TAG_RST;
    end else if (ce_l && tag_cnt_q != `SPC_TAG_DELAY) begin
      tag_cnt_q <= tag_cnt_q + 3'h1;
      if (tag_cnt_q == `SPC_TAG_DELAY - 3'h1) begin
        MODULE_TAG <= g_f_q & tag_m;
      end
    end
  end

  // ---------------- Checks ----------------
  a_addr_select: assert property (@(posedge CLK) disable iff (!RSTN)
    CE |=> BUS_ADDR == ($past(addr_sel_f) ? `SPC_ADDR_HIGH : `SPC_ADDR_LOW))
    else $error("bus address does not follow select pin");
  a_reset_safe: assert property (@(posedge CLK)
    !RSTN |=> !CORE_POWER_EN && !SERIAL_LINK_EN && !PLL_POWER_EN)
    else $error("outputs not safe after reset");
  a_standby_entry: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && standby_f |=> STANDBY_ACT && !SERIAL_LINK_EN)
    else $error("standby not entered");
  a_power_cut: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && off_f |=> !CORE_POWER_EN && !PLL_POWER_EN)
    else $error("core power not cut");
  a_pll_bypass: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && PLL_BYPASS |=> !PLL_CLK_SEL && !PLL_POWER_EN)
    else $error("multiplier not bypassed");
  a_lens_float: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && off_f |=> LENS_ACTUATOR_PINS_OE == 8'h00)
    else $error("lens pins driven while powered off");
  a_line_in_frame: assert property (@(posedge REF_CLK_IN)
    disable iff (!rst_l_q) LINE_VALID |-> FRAME_VALID && PAR_OUT_EN)
    else $error("line qualifier outside frame");
  a_fall_only: assert property (@(posedge REF_CLK_IN)
    disable iff (!rst_l_q)
    PAR_OUT_EN && $past(PAR_OUT_EN) &&
    ($changed(PIX_DATA) || $changed(LINE_VALID) || $changed(FRAME_VALID))
    |-> $fell(PIXEL_SAMPLE_CLK))
    else $error("outputs moved off the pixel clock fall");
  a_raw_msbs: assert property (@(posedge REF_CLK_IN)
    disable iff (!rst_l_q)
    step && lv_n && ctl_q.raw && par_on
    |=> PIX_DATA == $past(IMG_WORD[`SPC_RAW_MSB:`SPC_RAW_LSB]))
    else $error("raw bypass word not the sample MSBs");
  a_one_path: assert property (@(posedge REF_CLK_IN)
    disable iff (!rst_l_q)
    ce_l && ctl_q.serial |=> !PAR_OUT_EN && !PIXEL_SAMPLE_CLK)
    else $error("parallel port active with serial selected");
endmodule // spc_pin_port

// >>> spc_host_capture.sv
// Capture logic model on the far side of the parallel pixel port
`timescale 1ns/10ps
module spc_host_capture (
  input wire logic pclk,
  input wire logic [7:0] data,
  input wire logic lv,
  input wire logic fv,
  input wire logic [7:0] exp_data,
  output int frames,
  output int frame_pix,
  output int period,
  output logic frame_err
);
  int pix;
  int ticks;
  logic err;
  logic fv_q;
  initial begin
    frames = 0;
    frame_pix = 0;
    period = 0;
    frame_err = 1'b0;
    pix = 0;
    ticks = 0;
    err = 1'b0;
    fv_q = 1'b0;
  end
  // Sample on the rising pixel clock only; data moves on the fall
  always @(posedge pclk) begin
    fv_q <= fv;
    ticks <= ticks + 1;
    if (fv && !fv_q) begin
      period <= ticks;
      ticks <= 1;
    end
    if (fv_q && !fv) begin
      frames <= frames + 1;
      frame_pix <= pix;
      frame_err <= err;
      pix <= 0;
      err <= 1'b0;
    end else if (lv) begin
      pix <= pix + 1;
      if (data !== exp_data || fv !== 1'b1) begin
        err <= 1'b1;
      end
    end else if (data !== 8'h00) begin
      err <= 1'b1;
    end
  end
endmodule // spc_host_capture

// >>> tb.sv
// Self-checking testbench for the sensor pin control and pixel port
`timescale 1ns/10ps
module tb;
  localparam int COLS = 16;
  localparam int ROWS = 8;
  localparam int HBLANK = 4;
  localparam int VBLANK = 6;
  logic clk, rstn, ce, ref_clk, standby, pwr_off, addr_sel, pll_byp;
  logic raw, ser_sel, stby_act, core_en, pll_en, pll_sel, ser_en;
  logic pclk, lv, fv, par_en, frame_err;
  spc_pkg::spc_gpio_cfg_t gpio_func;
  logic [3:0] gpio_in, gpio_out, gpio_oe, mod_tag;
  logic [9:0] img_word;
  logic [7:0] lens_drive, lens_dir, exp_data, bus_addr, pix_data;
  logic [7:0] lens_o, lens_oe;
  int frames, frame_pix, period, bad_count, n_checks, f0, held;
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Link clock of 6.25 MHz stays inside the allowed input range
  initial begin
    ref_clk = 1'b0;
    #37;
    forever #80 ref_clk = ~ref_clk;
  end
  spc_pin_port #(.COLS(COLS), .ROWS(ROWS), .HBLANK(HBLANK),
    .VBLANK(VBLANK)) dut (.CLK(clk), .RSTN(rstn), .CE(ce),
    .REF_CLK_IN(ref_clk), .STANDBY_IN(standby),
    .CORE_POWER_OFF_IN(pwr_off), .BUS_ADDR_SELECT(addr_sel),
    .PLL_BYPASS(pll_byp), .RAW_BYPASS(raw), .SERIAL_SEL(ser_sel),
    .GPIO_FUNC(gpio_func), .GPIO_IN(gpio_in), .IMG_WORD(img_word),
    .LENS_DRIVE(lens_drive), .LENS_DIR(lens_dir), .BUS_ADDR(bus_addr),
    .STANDBY_ACT(stby_act), .CORE_POWER_EN(core_en),
    .PLL_POWER_EN(pll_en), .PLL_CLK_SEL(pll_sel),
    .SERIAL_LINK_EN(ser_en), .PIXEL_SAMPLE_CLK(pclk),
    .PIX_DATA(pix_data), .LINE_VALID(lv), .FRAME_VALID(fv),
    .PAR_OUT_EN(par_en), .GPIO_OUT(gpio_out), .GPIO_OE(gpio_oe),
    .MODULE_TAG(mod_tag), .LENS_ACTUATOR_PINS_O(lens_o),
    .LENS_ACTUATOR_PINS_OE(lens_oe));
  spc_host_capture host (.pclk(pclk), .data(pix_data), .lv(lv),
    .fv(fv), .exp_data(exp_data), .frames(frames),
    .frame_pix(frame_pix), .period(period), .frame_err(frame_err));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Bounded wait; a stalled pixel port ends the run
  task automatic wait_frames(input int n);
    f0 = frames;
    for (int i = 0; i < 20000 && frames < f0 + n; i++) begin
      @(negedge clk);
    end
    if (frames < f0 + n) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, frames,
        f0 + n);
      close_out();
    end
  endtask
  // Bounded wait for an active line on the port
  task automatic wait_line();
    for (int i = 0; i < 2000 && lv !== 1'b1; i++) begin
      @(negedge clk);
    end
    if (lv !== 1'b1) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, lv, 1'b1);
      close_out();
    end
  endtask
  initial begin
    bad_count = 0;
    n_checks = 0;
    f0 = $urandom(88107);
    rstn = 1'b0;
    ce = 1'b1;
    {standby, pwr_off, addr_sel, pll_byp, raw, ser_sel} = 6'h00;
    // The block has no factory test pin, so none is driven
    gpio_func[3] = spc_pkg::FN_STROBE;
    gpio_func[2] = spc_pkg::FN_TAG;
    gpio_func[1] = spc_pkg::FN_EXTRA1;
    gpio_func[0] = spc_pkg::FN_EXTRA0;
    gpio_in = 4'($urandom) & 4'h4;
    img_word = 10'($urandom);
    lens_drive = 8'($urandom);
    lens_dir = 8'($urandom);
    exp_data = img_word[7:0];
    cyc(5);
    chk({8'h00, bus_addr}, 16'h0078);
    chk({15'h0, core_en}, 16'h0000);
    cyc(5);
    rstn = 1'b1;
    cyc(8);
    chk({12'h0, pll_en, pll_sel, core_en, stby_act}, 16'h000e);
    chk({lens_o, lens_oe}, {lens_drive, lens_dir});
    chk({14'h0, gpio_oe[3:2]}, 16'h0002);
    addr_sel = 1'b1;
    cyc(8);
    chk({8'h00, bus_addr}, 16'h007a);
    addr_sel = 1'b0;
    cyc(8);
    chk({8'h00, bus_addr}, 16'h0078);
    chk({12'h0, mod_tag}, {12'h0, gpio_in & 4'h4});
    $display("test pins done");
    // Second frame after a mode change is wholly in the new mode
    for (int m = 0; m < 2; m++) begin
      raw = m[0];
      img_word = 10'($urandom);
      exp_data = raw ? img_word[9:2] : img_word[7:0];
      wait_frames(2);
      chk(16'(frame_pix), 16'(COLS * ROWS));
      chk(16'(period), 16'((COLS + HBLANK) * (ROWS + VBLANK)));
      chk({15'h0, frame_err}, 16'h0000);
      $display("test frame mode %0d done", m);
    end
    // Strobe, shutter and the extra low bits during an active raw line
    gpio_func[2] = spc_pkg::FN_SHUTTER;
    cyc(8);
    wait_line();
    chk({8'h00, gpio_out, gpio_oe},
      {8'h00, 2'b10, img_word[1:0], 4'hf});
    // Output-enable pin high stops the parallel port
    gpio_func[0] = spc_pkg::FN_OUT_EN;
    gpio_in[0] = 1'b1;
    cyc(20);
    chk({14'h0, par_en, pclk}, 16'h0000);
    gpio_in[0] = 1'b0;
    cyc(20);
    chk({15'h0, par_en}, 16'h0001);
    gpio_func[0] = spc_pkg::FN_EXTRA0;
    // In trigger mode frames wait for a rising trigger pin
    gpio_func[1] = spc_pkg::FN_TRIGGER;
    cyc(1200);
    held = frames;
    cyc(1000);
    chk(16'(frames), 16'(held));
    gpio_in[1] = 1'b1;
    wait_frames(1);
    chk(16'(frame_pix), 16'(COLS * ROWS));
    chk({15'h0, frame_err}, 16'h0000);
    gpio_in[1] = 1'b0;
    gpio_func[1] = spc_pkg::FN_EXTRA1;
    $display("test gpio done");
    standby = 1'b1;
    cyc(8);
    chk({14'h0, stby_act, ser_en}, 16'h0002);
    cyc(1200);
    chk({15'h0, pclk}, 16'h0000);
    standby = 1'b0;
    cyc(8);
    chk({15'h0, stby_act}, 16'h0000);
    // A frame cut by standby leaves partial frames; the third is whole
    wait_frames(3);
    chk(16'(frame_pix), 16'(COLS * ROWS));
    chk({15'h0, frame_err}, 16'h0000);
    $display("test standby done");
    pwr_off = 1'b1;
    cyc(8);
    chk({7'h0, core_en, lens_oe}, 16'h0000);
    pwr_off = 1'b0;
    cyc(8);
    chk({7'h0, core_en, lens_oe}, {8'h01, lens_dir});
    $display("test power done");
    ser_sel = 1'b1;
    cyc(20);
    chk({13'h0, ser_en, par_en, pclk}, 16'h0004);
    ser_sel = 1'b0;
    cyc(20);
    chk({14'h0, ser_en, par_en}, 16'h0001);
    pll_byp = 1'b1;
    cyc(8);
    chk({14'h0, pll_en, pll_sel}, 16'h0000);
    $display("test paths done");
    addr_sel = 1'b1;
    cyc(8);
    rstn = 1'b0;
    cyc(5);
    chk({8'h00, bus_addr}, 16'h0078);
    $display("test reset done");
    close_out();
  end
endmodule // tb
